// [pkg/spi_core_pkg.sv]
// shared constants and types for the serial shift core
package spi_core_pkg;
  localparam int unsigned  DATA_W          = 16;
  localparam int unsigned  NUM_CS          = 4;
  localparam int unsigned  CS_IDX_W        = 2;
  localparam int unsigned  BITS_W          = 5;
  localparam int unsigned  DIV_W           = 8;
  localparam int unsigned  DLY_W           = 8;
  localparam logic [4:0]   MIN_BITS        = 5'h08;
  localparam logic [4:0]   MAX_BITS        = 5'h10;
  localparam logic [7:0]   DIV_INVALID     = 8'h00;
  localparam logic [15:0]  DUMMY_WORD      = 16'hFFFF;
  localparam logic [15:0]  TDR_RESET       = 16'h0000;
  localparam logic [15:0]  RDR_RESET       = 16'h0000;
  localparam logic [3:0]   CS_ALL_HIGH     = 4'hF;
  localparam logic [3:0]   CS_OE_ALL       = 4'hF;
  localparam int unsigned  IRQ_RDRF        = 0;
  localparam int unsigned  IRQ_TDRE        = 1;
  localparam int unsigned  IRQ_OVR         = 2;
  localparam int unsigned  IRQ_TXEMPTY     = 3;
  localparam int unsigned  IRQ_W           = 4;
  localparam real          CLK_PERIOD_NS   = 8.0;

  typedef logic [DATA_W-1:0] word_t;
  typedef logic [BITS_W-1:0] bits_t;
  typedef logic [DIV_W-1:0]  div_t;
  typedef logic [DLY_W-1:0]  dly_t;
endpackage

// [pkg/shift_if.sv]
// link between the sequencer and the shift engine
interface shift_if;
  import spi_core_pkg::*;
  logic  load;
  word_t load_data;
  bits_t bits;
  logic  phase;
  logic  lead;
  logic  trail;
  logic  in_bit;
  logic  out_bit;
  word_t rx_word;
  logic  done;

  modport ctrl (output load, load_data, bits, phase, lead, trail, in_bit,
                input  out_bit, rx_word, done);
  modport eng  (input  load, load_data, bits, phase, lead, trail, in_bit,
                output out_bit, rx_word, done);
endinterface

// [core/shift_engine.sv]
// single shift register: serial out and serial in through the same register
module shift_engine
  import spi_core_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // sequencer side
  shift_if.eng      sh
);
  typedef struct packed {
    word_t sreg;
    logic  sample;
    logic  out;
    bits_t cnt;
  } eng_s;

  eng_s  r_q;
  eng_s  r_d;
  logic [3:0] msb;
  word_t      shifted;

  always_comb
  begin
    r_d     = r_q;
    msb     = 4'(sh.bits - 5'h01);
    shifted = {r_q.sreg[DATA_W-2:0], (sh.phase ? r_q.sample : sh.in_bit)};
    if (sh.load)
    begin
      r_d.sreg = sh.load_data;
      r_d.out  = sh.load_data[msb];
      r_d.cnt  = sh.bits;
    end
    else if (sh.lead && r_q.cnt != '0)
    begin
      if (sh.phase)
        r_d.sample = sh.in_bit;
      else
        r_d.out = r_q.sreg[msb];
    end
    else if (sh.trail && r_q.cnt != '0)
    begin
      r_d.sreg = shifted;
      r_d.cnt  = r_q.cnt - 5'h01;
      if (sh.phase)
        r_d.out = shifted[msb];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign sh.out_bit = r_q.out;
  // done ignores load, so the sequencer may reload on the last edge without a loop
  assign sh.done    = sh.trail && r_q.cnt == 5'h01;
  // word including the bit of the current trailing shift, taken on done
  assign sh.rx_word = shifted & (DUMMY_WORD >> (5'(DATA_W) - sh.bits));
endmodule

// [core/spi_master_slave_shift_core.sv]
// serial shift core: master sequencer, slave front end, holding registers
module spi_master_slave_shift_core
  import spi_core_pkg::*;
#(
  parameter int unsigned N_CS = NUM_CS
)
(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  // mode and control
  input  wire logic                   enable_in,
  input  wire logic                   master_select_bit_in,
  input  wire logic                   decode_mode_in,
  input  wire logic [3:0]             peripheral_chip_select_in,
  input  wire logic [IRQ_W-1:0]       irq_enable_in,
  // per chip select configuration, and the one shared gap between selects
  input  wire logic [N_CS-1:0]        clock_idle_polarity_in,
  input  wire logic [N_CS-1:0]        clock_capture_phase_in,
  input  spi_core_pkg::bits_t         word_bits_in [N_CS],
  input  spi_core_pkg::div_t          serial_clock_divisor_in [N_CS],
  input  spi_core_pkg::dly_t          delay_before_clock_in [N_CS],
  input  spi_core_pkg::dly_t          delay_between_xfer_in [N_CS],
  input  spi_core_pkg::dly_t          delay_between_cs_in,
  // holding registers
  input  spi_core_pkg::word_t         transmit_holding_register_in,
  input  wire logic                   tx_write_in,
  input  wire logic                   rx_read_in,
  input  wire logic                   status_read_in,
  output spi_core_pkg::word_t         rx_data_out,
  output logic                        rx_full_out,
  output logic                        tx_empty_out,
  output logic                        overrun_out,
  output logic                        idle_out,
  // dma and interrupt
  output logic                        rx_dma_req_out,
  output logic                        tx_dma_req_out,
  output logic                        irq_out,
  // serial pins
  output logic                        sck_out,
  output logic                        sck_oe_out,
  input  wire logic                   sck_in,
  output logic                        mosi_out,
  output logic                        mosi_oe_out,
  input  wire logic                   mosi_in,
  output logic                        miso_out,
  output logic                        miso_oe_out,
  input  wire logic                   miso_in,
  output logic [3:0]                  chip_select_out,
  output logic [3:0]                  chip_select_oe_out,
  input  wire logic                   chip_select_zero_in
);
  import spi_core_pkg::*;

  if (N_CS != NUM_CS)
  begin : g_check
    $error("core serves exactly four chip selects");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_CS_GAP, ST_SETUP, ST_SHIFT, ST_HOLD} mst_e;

  typedef struct packed {
    mst_e                st;
    word_t               tdr;
    logic                tdre;
    word_t               rdr;
    logic                rdrf;
    logic                ovr;
    dly_t                cnt;
    logic                half;
    logic [CS_IDX_W-1:0] idx;
    logic [3:0]          sel;
    logic [3:0]          last_sel;
    logic                have_last;
    logic [3:0]          cs;
    logic                sck;
    logic                sck_s1;
    logic                sck_s2;
    logic                sck_s3;
    logic                ss_s1;
    logic                ss_s2;
    logic                ss_s3;
  } core_s;

  core_s r_q;
  core_s r_d;

  shift_if sh ();

  shift_engine u_engine (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .sh        (sh.eng)
  );

  // one-hot active-low pattern, or raw code for an external decoder
  function automatic logic [3:0] cs_pattern(input logic dec, input logic [3:0] pcs);
    logic [3:0] p;
    p = 4'h7;
    if (dec)
      p = pcs;
    else if (!pcs[0])
      p = 4'hE;
    else if (!pcs[1])
      p = 4'hD;
    else if (!pcs[2])
      p = 4'hB;
    return p;
  endfunction

  function automatic logic [CS_IDX_W-1:0] cs_index(input logic dec, input logic [3:0] pcs);
    logic [CS_IDX_W-1:0] i;
    i = 2'h3;
    if (dec)
      i = pcs[3:2];
    else if (!pcs[0])
      i = 2'h0;
    else if (!pcs[1])
      i = 2'h1;
    else if (!pcs[2])
      i = 2'h2;
    return i;
  endfunction

  function automatic bits_t clamp_bits(input bits_t b);
    return (b < MIN_BITS) ? MIN_BITS : ((b > MAX_BITS) ? MAX_BITS : b);
  endfunction

  logic [CS_IDX_W-1:0] new_idx;
  logic [3:0]          new_sel;
  logic [CS_IDX_W-1:0] cfg_idx;
  logic                master;
  logic                pol;
  logic                ss_low;
  logic                s_lead;
  logic                s_trail;
  logic                ld_taken;

  assign master  = master_select_bit_in;
  assign new_idx = cs_index(decode_mode_in, peripheral_chip_select_in);
  assign new_sel = cs_pattern(decode_mode_in, peripheral_chip_select_in);
  assign cfg_idx = master ? r_q.idx : '0;
  assign pol     = clock_idle_polarity_in[cfg_idx];
  assign ss_low  = !r_q.ss_s2;
  // slave edges from the synchronised incoming clock
  assign s_lead  = ss_low && r_q.sck_s3 == pol && r_q.sck_s2 != pol;
  assign s_trail = ss_low && r_q.sck_s3 != pol && r_q.sck_s2 == pol;

  always_comb
  begin
    r_d          = r_q;
    sh.load      = 1'b0;
    sh.load_data = r_q.tdre ? DUMMY_WORD : r_q.tdr;
    // new select only while idle; the running word keeps its own length
    sh.bits      = clamp_bits(word_bits_in[(master && r_q.st == ST_IDLE) ? new_idx : cfg_idx]);
    sh.phase     = clock_capture_phase_in[cfg_idx];
    sh.lead      = 1'b0;
    sh.trail     = 1'b0;
    sh.in_bit    = master ? miso_in : mosi_in;
    ld_taken     = 1'b0;
    r_d.sck_s1   = sck_in;
    r_d.sck_s2   = r_q.sck_s1;
    r_d.sck_s3   = r_q.sck_s2;
    r_d.ss_s1    = chip_select_zero_in;
    r_d.ss_s2    = r_q.ss_s1;
    r_d.ss_s3    = r_q.ss_s2;

    if (master && enable_in)
    begin
      case (r_q.st)
        ST_IDLE:
        begin
          r_d.cs = CS_ALL_HIGH;
          if (!r_q.tdre && serial_clock_divisor_in[new_idx] != DIV_INVALID)
          begin
            sh.load   = 1'b1;
            ld_taken  = 1'b1;
            r_d.idx   = new_idx;
            r_d.sel   = new_sel;
            if (r_q.have_last && r_q.last_sel != new_sel)
            begin
              r_d.st  = ST_CS_GAP;
              r_d.cnt = delay_between_cs_in;
            end
            else
            begin
              r_d.st  = ST_SETUP;
              r_d.cnt = delay_before_clock_in[new_idx];
            end
          end
        end
        ST_CS_GAP:
        begin
          r_d.cnt = r_q.cnt - 8'h01;
          if (r_q.cnt == '0)
          begin
            r_d.st  = ST_SETUP;
            r_d.cnt = delay_before_clock_in[r_q.idx];
          end
        end
        ST_SETUP:
        begin
          r_d.cs  = r_q.sel;
          r_d.cnt = r_q.cnt - 8'h01;
          if (r_q.cnt == '0)
          begin
            r_d.st   = ST_SHIFT;
            r_d.half = 1'b0;
            r_d.cnt  = serial_clock_divisor_in[r_q.idx] - 8'h01;
          end
        end
        ST_SHIFT:
        begin
          // baud generator: half period of divisor clock cycles
          r_d.cnt = r_q.cnt - 8'h01;
          if (r_q.cnt == '0)
          begin
            r_d.cnt  = serial_clock_divisor_in[r_q.idx] - 8'h01;
            r_d.half = !r_q.half;
            sh.lead  = !r_q.half;
            sh.trail = r_q.half;
          end
          if (sh.done)
          begin
            r_d.st  = ST_HOLD;
            r_d.cnt = delay_between_xfer_in[r_q.idx];
          end
        end
        ST_HOLD:
        begin
          r_d.cnt = r_q.cnt - 8'h01;
          if (r_q.cnt == '0)
          begin
            r_d.st        = ST_IDLE;
            r_d.cs        = CS_ALL_HIGH;
            r_d.last_sel  = r_q.sel;
            r_d.have_last = 1'b1;
          end
        end
        default:
          r_d.st = ST_IDLE;
      endcase
    end
    else
    begin
      r_d.st   = ST_IDLE;
      r_d.cs   = CS_ALL_HIGH;
      r_d.half = 1'b0;
      if (!master && enable_in)
      begin
        sh.lead  = s_lead;
        sh.trail = s_trail;
        if ((r_q.ss_s3 && !r_q.ss_s2) || (sh.done && ss_low))
        begin
          sh.load  = 1'b1;
          ld_taken = !r_q.tdre;
        end
      end
    end

    // idle clock level follows the active configuration
    r_d.sck = pol ^ (master && r_q.st == ST_SHIFT && r_d.half);

    if (tx_write_in && enable_in)
    begin
      r_d.tdr  = transmit_holding_register_in;
      r_d.tdre = 1'b0;
    end
    else if (ld_taken)
      r_d.tdre = 1'b1;

    if (rx_read_in)
      r_d.rdrf = 1'b0;
    if (status_read_in)
      r_d.ovr = 1'b0;
    if (sh.done)
    begin
      r_d.rdr  = sh.rx_word;
      r_d.rdrf = 1'b1;
      if (r_q.rdrf && !rx_read_in)
        r_d.ovr = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      r_q          <= '0;
      r_q.st       <= ST_IDLE;
      r_q.tdr      <= TDR_RESET;
      r_q.rdr      <= RDR_RESET;
      r_q.tdre     <= 1'b1;
      r_q.cs       <= CS_ALL_HIGH;
      r_q.last_sel <= CS_ALL_HIGH;
      r_q.sel      <= CS_ALL_HIGH;
      r_q.ss_s1    <= 1'b1;
      r_q.ss_s2    <= 1'b1;
      r_q.ss_s3    <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  assign rx_data_out        = r_q.rdr;
  assign rx_full_out        = r_q.rdrf;
  assign tx_empty_out       = r_q.tdre;
  assign overrun_out        = r_q.ovr;
  assign idle_out           = r_q.tdre && r_q.st == ST_IDLE;
  assign rx_dma_req_out     = r_q.rdrf;
  assign tx_dma_req_out     = r_q.tdre && enable_in;
  assign irq_out            = (r_q.rdrf && irq_enable_in[IRQ_RDRF])
                           || (r_q.tdre && irq_enable_in[IRQ_TDRE])
                           || (r_q.ovr  && irq_enable_in[IRQ_OVR])
                           || (idle_out && irq_enable_in[IRQ_TXEMPTY]);
  assign sck_out            = r_q.sck;
  assign sck_oe_out         = master;
  assign mosi_out           = sh.out_bit;
  assign mosi_oe_out        = master;
  assign miso_out           = sh.out_bit;
  assign miso_oe_out        = !master && ss_low;
  assign chip_select_out    = r_q.cs;
  assign chip_select_oe_out = master ? CS_OE_ALL : 4'h0;
endmodule

// [verif/spi_core_asserts.sv]
// port-level checks of the serial shift core
module spi_core_asserts
  import spi_core_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // control
  input  wire logic             enable_in,
  input  wire logic             master_select_bit_in,
  input  wire logic [IRQ_W-1:0] irq_enable_in,
  input  wire logic             tx_write_in,
  // status
  input  wire logic             rx_full_out,
  input  wire logic             tx_empty_out,
  input  wire logic             overrun_out,
  input  wire logic             idle_out,
  input  wire logic             rx_dma_req_out,
  input  wire logic             tx_dma_req_out,
  input  wire logic             irq_out,
  // pins
  input  wire logic             sck_out,
  input  wire logic             sck_oe_out,
  input  wire logic             mosi_oe_out,
  input  wire logic             miso_oe_out,
  input  wire logic [3:0]       chip_select_out,
  input  wire logic [3:0]       chip_select_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_master_pins;
    master_select_bit_in && $past(master_select_bit_in) |->
      sck_oe_out && mosi_oe_out && chip_select_oe_out == 4'hF;
  endproperty
  a_master_pins: assert property (p_master_pins)
    else $error("master pin directions wrong");

  property p_slave_pins;
    !master_select_bit_in && !$past(master_select_bit_in) |->
      !sck_oe_out && !mosi_oe_out && chip_select_oe_out == 4'h0;
  endproperty
  a_slave_pins: assert property (p_slave_pins)
    else $error("slave pin directions wrong");

  property p_miso_slave_only;
    miso_oe_out |-> !master_select_bit_in;
  endproperty
  a_miso_slave_only: assert property (p_miso_slave_only)
    else $error("miso driven in master mode");

  property p_no_slave_clock;
    !master_select_bit_in [*3] |-> $stable(sck_out);
  endproperty
  a_no_slave_clock: assert property (p_no_slave_clock)
    else $error("clock moves in slave mode");

  property p_cs_idle_high;
    master_select_bit_in && idle_out && $past(idle_out) |-> chip_select_out == 4'hF;
  endproperty
  a_cs_idle_high: assert property (p_cs_idle_high)
    else $error("select low while idle");

  property p_write_clears_empty;
    tx_write_in && enable_in |=> !tx_empty_out;
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty)
    else $error("holding register write not seen");

  property p_dma_requests;
    rx_dma_req_out == rx_full_out && tx_dma_req_out == (tx_empty_out && enable_in);
  endproperty
  a_dma_requests: assert property (p_dma_requests)
    else $error("dma request mismatch");

  property p_irq_line;
    irq_out == |(irq_enable_in & {idle_out, overrun_out, tx_empty_out, rx_full_out});
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("interrupt line mismatch");

  property p_overrun_cause;
    $rose(overrun_out) |-> $past(rx_full_out);
  endproperty
  a_overrun_cause: assert property (p_overrun_cause)
    else $error("overrun without full receiver");
endmodule

bind spi_master_slave_shift_core spi_core_asserts chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .enable_in(enable_in),
  .master_select_bit_in(master_select_bit_in), .irq_enable_in(irq_enable_in),
  .tx_write_in(tx_write_in), .rx_full_out(rx_full_out), .tx_empty_out(tx_empty_out),
  .overrun_out(overrun_out), .idle_out(idle_out), .rx_dma_req_out(rx_dma_req_out),
  .tx_dma_req_out(tx_dma_req_out), .irq_out(irq_out), .sck_out(sck_out),
  .sck_oe_out(sck_oe_out), .mosi_oe_out(mosi_oe_out), .miso_oe_out(miso_oe_out),
  .chip_select_out(chip_select_out), .chip_select_oe_out(chip_select_oe_out));

// [verif/spi_slave_model.sv]
// behavioural serial slave on the far side of the master pins
module spi_slave_model
(
  input  wire logic        sck_in,
  input  wire logic        mosi_in,
  input  wire logic        sel_n_in,
  input  wire logic        idle_pol_in,
  input  wire logic        cpha_in,
  input  wire logic [4:0]  bits_in,
  input  wire logic [15:0] word_in,
  output logic             miso_out,
  output logic [15:0]      rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh;

  initial
  begin
    miso_out = 1'b0;
    rx_out = 16'h0000;
    sh = 16'h0000;
  end

  always @(negedge sel_n_in)
  begin
    sh = word_in << (5'h10 - bits_in);
    rx_out = 16'h0000;
    if (cpha_in) miso_out = sh[15];
  end

  // released line must not keep its last value
  always @(posedge sel_n_in) miso_out = ~miso_out;

  always @(sck_in)
    if (!sel_n_in)
    begin
      if ((sck_in != idle_pol_in) == cpha_in) rx_out = {rx_out[14:0], mosi_in};
      else if (cpha_in)
      begin
        sh = sh << 1;
        miso_out = sh[15];
      end
      else
      begin
        miso_out = sh[15];
        sh = sh << 1;
      end
    end
endmodule

// [verif/testbench.sv]
// self-checking bench for the serial shift core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_core_pkg::*;
  logic        clk_in, resetn_in, enable_in, master_select_bit_in, decode_mode_in;
  logic [3:0]  peripheral_chip_select_in, irq_enable_in, clock_idle_polarity_in;
  logic [3:0]  clock_capture_phase_in, chip_select_out, chip_select_oe_out, cs_seen, prev_cs;
  bits_t       word_bits_in [4];
  div_t        serial_clock_divisor_in [4];
  dly_t        delay_before_clock_in [4];
  dly_t        delay_between_xfer_in [4];
  dly_t        delay_between_cs_in;
  word_t       transmit_holding_register_in, rx_data_out, m_word, m_rx;
  logic        tx_write_in, rx_read_in, status_read_in, rx_full_out, tx_empty_out, idle_out;
  logic        overrun_out, rx_dma_req_out, tx_dma_req_out, irq_out, sck_out, sck_oe_out;
  logic        sck_in, mosi_out, mosi_oe_out, mosi_in, miso_out, miso_oe_out, miso_in;
  logic        chip_select_zero_in, m_pol, m_cpha, exp_pol, last_sck;
  bits_t       m_bits;
  logic [15:0] sck_edges;
  logic [31:0] rnd;
  int          fail_count, check_count;

  spi_master_slave_shift_core dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .enable_in(enable_in), .master_select_bit_in(master_select_bit_in),
    .decode_mode_in(decode_mode_in), .peripheral_chip_select_in(peripheral_chip_select_in),
    .irq_enable_in(irq_enable_in), .clock_idle_polarity_in(clock_idle_polarity_in),
    .clock_capture_phase_in(clock_capture_phase_in), .word_bits_in(word_bits_in),
    .serial_clock_divisor_in(serial_clock_divisor_in),
    .delay_before_clock_in(delay_before_clock_in),
    .delay_between_xfer_in(delay_between_xfer_in), .delay_between_cs_in(delay_between_cs_in),
    .transmit_holding_register_in(transmit_holding_register_in), .tx_write_in(tx_write_in),
    .rx_read_in(rx_read_in), .status_read_in(status_read_in), .rx_data_out(rx_data_out),
    .rx_full_out(rx_full_out), .tx_empty_out(tx_empty_out), .overrun_out(overrun_out),
    .idle_out(idle_out), .rx_dma_req_out(rx_dma_req_out), .tx_dma_req_out(tx_dma_req_out),
    .irq_out(irq_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .sck_in(sck_in),
    .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .mosi_in(mosi_in), .miso_out(miso_out),
    .miso_oe_out(miso_oe_out), .miso_in(miso_in), .chip_select_out(chip_select_out),
    .chip_select_oe_out(chip_select_oe_out), .chip_select_zero_in(chip_select_zero_in));

  spi_slave_model far (.sck_in(sck_out), .mosi_in(mosi_out), .sel_n_in(&chip_select_out),
    .idle_pol_in(m_pol), .cpha_in(m_cpha), .bits_in(m_bits), .word_in(m_word),
    .miso_out(miso_in), .rx_out(m_rx));

  always #4 clk_in = ~clk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic word_t low_mask(input bits_t nb);
    return word_t'((17'h1 << nb) - 17'h1);
  endfunction

  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // per-select config, then one holding register write
  task automatic setup(input logic [1:0] ci, input logic [3:0] code, input logic pol,
                       input logic pha, input bits_t nb, input div_t d);
    cyc(1);
    peripheral_chip_select_in = code;
    clock_idle_polarity_in[ci] = pol;
    clock_capture_phase_in[ci] = pha;
    word_bits_in[ci] = nb;
    serial_clock_divisor_in[ci] = d;
    {m_pol, m_cpha, m_bits, exp_pol} = {pol, pha, nb, pol};
    rnd = lfsr(rnd);
    m_word = rnd[15:0];
    rnd = lfsr(rnd);
    transmit_holding_register_in = rnd[31:16];
    delay_before_clock_in[ci] = dly_t'(rnd[1:0]);
    delay_between_xfer_in[ci] = dly_t'(rnd[3:2]);
    cs_seen = 4'hF;
    sck_edges = 16'h0000;
    tx_write_in = 1'b1;
    cyc(1);
    tx_write_in = 1'b0;
    check(tx_empty_out, 1'b0);
  endtask

  task automatic finish(input logic [3:0] exp_cs, input logic rd);
    int n;
    n = 0;
    cyc(3);
    while (idle_out !== 1'b1 && n < 5000)
    begin
      cyc(1);
      n++;
    end
    check(idle_out, 1'b1);
    cyc(2);
    check(rx_data_out, m_word & low_mask(m_bits));
    check(m_rx, transmit_holding_register_in & low_mask(m_bits));
    check(cs_seen, exp_cs);
    check(sck_edges, 16'(2 * m_bits));
    check(chip_select_out, 4'hF);
    rx_read_in = rd;
    cyc(1);
    rx_read_in = 1'b0;
  endtask

  always @(negedge clk_in)
  begin
    if (master_select_bit_in && chip_select_out != 4'hF && prev_cs == 4'hF)
      check(sck_out, exp_pol);
    if (chip_select_out != 4'hF)
    begin
      cs_seen <= chip_select_out;
      if (sck_out != last_sck) sck_edges <= sck_edges + 16'h0001;
    end
    prev_cs <= chip_select_out;
    last_sck <= sck_out;
  end

  initial
  begin
    #160000;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [1:0] ci;
    logic [3:0] code;
    logic [7:0] sw;
    {clk_in, resetn_in, enable_in, master_select_bit_in, decode_mode_in} = 5'b00110;
    {tx_write_in, rx_read_in, status_read_in, sck_in, mosi_in} = 5'b00000;
    {chip_select_zero_in, m_pol, m_cpha, exp_pol, last_sck} = 5'b10000;
    {peripheral_chip_select_in, irq_enable_in, prev_cs, cs_seen} = 16'hE0FF;
    {clock_idle_polarity_in, clock_capture_phase_in} = 8'h00;
    {m_bits, m_word, sck_edges, transmit_holding_register_in} = '0;
    foreach (word_bits_in[k])
    begin
      word_bits_in[k] = 5'h08;
      serial_clock_divisor_in[k] = 8'h02;
      delay_before_clock_in[k] = 8'h00;
      delay_between_xfer_in[k] = 8'h00;
    end
    delay_between_cs_in = 8'h01;
    {rnd, fail_count, check_count} = {32'hE3A5, 64'h0};
    cyc(3);
    resetn_in = 1'b1;
    cyc(2);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      ci = rnd[1:0];
      irq_enable_in = rnd[11:8];
      decode_mode_in = (i == 7);
      code = decode_mode_in ? {ci, 2'b01} : 4'(~(4'h1 << ci));
      setup(decode_mode_in ? code[3:2] : ci, code, i[0], i[1],
            (i == 0) ? 5'h08 : (i == 1) ? 5'h10 : bits_t'(5'h08 + 5'(rnd[7:4] % 9)),
            (i == 0) ? 8'h01 : div_t'(8'h02 + 8'(rnd[13:12])));
      finish(code, 1'b1);
    end
    decode_mode_in = 1'b0;
    irq_enable_in = 4'h1;
    setup(2'h1, 4'hD, 1'b0, 1'b1, 5'h08, 8'h00);
    cyc(40);
    check(chip_select_out, 4'hF);
    check(tx_empty_out, 1'b0);
    serial_clock_divisor_in[1] = 8'h03;
    finish(4'hD, 1'b0);
    check(irq_out, 1'b1);
    setup(2'h1, 4'hD, 1'b1, 1'b0, 5'h0C, 8'h02);
    finish(4'hD, 1'b0);
    check(overrun_out, 1'b1);
    status_read_in = 1'b1;
    cyc(1);
    status_read_in = 1'b0;
    rx_read_in = 1'b1;
    cyc(1);
    rx_read_in = 1'b0;
    cyc(1);
    check(overrun_out, 1'b0);
    check(irq_out, 1'b0);
    master_select_bit_in = 1'b0;
    {word_bits_in[0], clock_idle_polarity_in[0], clock_capture_phase_in[0]} = 7'h11;
    rnd = lfsr(rnd);
    {sw, transmit_holding_register_in} = {rnd[15:8], 8'h00, rnd[7:0]};
    tx_write_in = 1'b1;
    cyc(1);
    tx_write_in = 1'b0;
    cyc(4);
    chip_select_zero_in = 1'b0;
    cyc(8);
    check(miso_oe_out, 1'b1);
    for (int b = 7; b >= 0; b--)
    begin
      mosi_in = sw[b];
      cyc(8);
      check(miso_out, transmit_holding_register_in[b]);
      sck_in = 1'b1;
      cyc(8);
      sck_in = 1'b0;
      cyc(8);
    end
    chip_select_zero_in = 1'b1;
    mosi_in = ~mosi_in;
    cyc(8);
    check(rx_data_out, {8'h00, sw});
    check(miso_oe_out, 1'b0);
    tally_and_finish();
  end
endmodule
